/* verilog/bpd_pkg.sv */
// Package for the shared-pin general-purpose port: register map,
// field positions, reset values and output-mode codes.
// Assumes a byte-addressed 32-bit Avalon-MM register window.
`default_nettype none

package bpd_pkg;

	// Port width
	localparam int BPD_WIDTH = 8;

	// Register byte offsets
	localparam logic [4:0] BPD_OFS_PIN_LEVEL = 5'h00;
	localparam logic [4:0] BPD_OFS_LATCH     = 5'h04;
	localparam logic [4:0] BPD_OFS_DIR       = 5'h08;
	localparam logic [4:0] BPD_OFS_COMPANION = 5'h0C;
	localparam logic [4:0] BPD_OFS_PARALLEL  = 5'h10;
	localparam logic [4:0] BPD_OFS_PWM       = 5'h14;

	// Field positions
	localparam int BPD_COMP_PULLUP_BIT = 7;
	localparam int BPD_PAR_EN_BIT      = 0;
	localparam int BPD_PWM_ACTIVE_BIT  = 0;
	localparam int BPD_PWM_MODE_LSB    = 1;
	localparam int BPD_PWM_MODE_MSB    = 2;
	localparam int BPD_PWM_TRI_BIT     = 3;

	// Pins carrying the extra PWM channels
	localparam int BPD_PIN_PWM_B = 5;
	localparam int BPD_PIN_PWM_C = 6;
	localparam int BPD_PIN_PWM_D = 7;

	// PWM output-mode codes
	localparam logic [1:0] BPD_PWM_SINGLE   = 2'h0;
	localparam logic [1:0] BPD_PWM_QUAD_FWD = 2'h1;
	localparam logic [1:0] BPD_PWM_DUAL     = 2'h2;
	localparam logic [1:0] BPD_PWM_QUAD_REV = 2'h3;

	// Values after reset
	localparam logic [7:0] BPD_RST_LATCH   = 8'h00;
	localparam logic [7:0] BPD_RST_DIR     = 8'hFF;
	localparam logic       BPD_RST_PULLUP  = 1'b0;
	localparam logic       BPD_RST_PAR_EN  = 1'b0;
	localparam logic [3:0] BPD_RST_PWM     = 4'h0;
	localparam logic [7:0] BPD_RST_PIN     = 8'h00;
	localparam logic [31:0] BPD_RST_RDATA  = 32'h0000_0000;

endpackage

`default_nettype wire

/* verilog/bpd_pin_sync.sv */
// Three-stage pin synchroniser with an agreement filter, one per bit.
// Assumes asynchronous pin levels and a synchronous active-low reset copy.
`timescale 1ns/1ps
`default_nettype none

module bpd_pin_sync
	import bpd_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 ce,
	input  wire logic [BPD_WIDTH-1:0] pin_async,
	output logic      [BPD_WIDTH-1:0] pin_level
);

	logic [BPD_WIDTH-1:0] stage1;
	logic [BPD_WIDTH-1:0] stage2;
	logic [BPD_WIDTH-1:0] stage3;

	// Stage one feeds only stage two, never the filter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= BPD_RST_PIN;
			stage2 <= BPD_RST_PIN;
			stage3 <= BPD_RST_PIN;
		end else if (ce) begin
			stage1 <= pin_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// A new level counts once stages two and three agree
	genvar i;
	for (i = 0; i < BPD_WIDTH; i++) begin : g_filt
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n)
				pin_level[i] <= BPD_RST_PIN[i];
			else if (ce && (stage2[i] == stage3[i]))
				pin_level[i] <= stage3[i];
		end
	end

endmodule

`default_nettype wire

/* verilog/bpd_pin_mux.sv */
// Per-pin priority mux: PWM over parallel bus over port latch.
// Pure combinational; the caller registers every result.
`timescale 1ns/1ps
`default_nettype none

module bpd_pin_mux
	import bpd_pkg::*;
(
	input  wire logic [BPD_WIDTH-1:0] dir,
	input  wire logic [BPD_WIDTH-1:0] latch,
	input  wire logic                 pullup_master,
	input  wire logic                 par_en,
	input  wire logic                 par_drive,
	input  wire logic [BPD_WIDTH-1:0] par_data,
	input  wire logic [BPD_WIDTH-1:0] pwm_assign,
	input  wire logic [BPD_WIDTH-1:0] pwm_data,
	input  wire logic                 pwm_tristate,
	output logic      [BPD_WIDTH-1:0] next_out,
	output logic      [BPD_WIDTH-1:0] next_oe,
	output logic      [BPD_WIDTH-1:0] next_pullup
);

	wire par_pin = par_en & par_drive;

	// Each pin decided on its own
	genvar i;
	for (i = 0; i < BPD_WIDTH; i++) begin : g_pin
		wire pwm_pin = pwm_assign[i] & ~dir[i];
		wire periph  = pwm_assign[i] | par_en;
		assign next_oe[i] = pwm_pin ? ~pwm_tristate
					    : (par_pin | ~dir[i]);
		assign next_out[i] = pwm_pin ? pwm_data[i]
				     : par_pin ? par_data[i] : latch[i];
		assign next_pullup[i] = pullup_master & latch[i] & dir[i]
					& ~periph;
	end

endmodule

`default_nettype wire

/* verilog/bpd_port.sv */
// Top of the shared-pin general-purpose port with its register slave.
// Assumes a 40 MHz clk, Avalon-MM master on the same clock, parallel
// bus and PWM sources on the same clock, pins asynchronous.
`timescale 1ns/1ps
`default_nettype none

module bpd_port
	import bpd_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire logic                 ce,
	input  wire logic [4:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	input  wire logic [BPD_WIDTH-1:0] pin_in,
	output logic      [BPD_WIDTH-1:0] pin_out,
	output logic      [BPD_WIDTH-1:0] pin_oe,
	output logic      [BPD_WIDTH-1:0] pin_pullup_en,
	input  wire logic                 par_drive,
	input  wire logic [BPD_WIDTH-1:0] par_out_data,
	output logic      [BPD_WIDTH-1:0] par_in_data,
	output logic                      par_port_enable,
	input  wire logic                 pwm_out_b,
	input  wire logic                 pwm_out_c,
	input  wire logic                 pwm_out_d,
	input  wire logic                 pwm_shutdown,
	output logic                      serial_unit_port_disable
);

	// Reset synchroniser stages
	logic                 rst_meta;
	logic                 rst_n;

	// Software-visible state
	logic [BPD_WIDTH-1:0] output_latch_reg;
	logic [BPD_WIDTH-1:0] direction_reg;
	logic                 pullup_master_enable;
	logic                 par_enable;
	logic                 pwm_active;
	logic [1:0]           pwm_mode;
	logic                 pwm_tri_on_shutdown;

	// Filtered pin levels
	logic [BPD_WIDTH-1:0] pin_level;

	// Mux results, registered below
	logic [BPD_WIDTH-1:0] next_out;
	logic [BPD_WIDTH-1:0] next_oe;
	logic [BPD_WIDTH-1:0] next_pullup;

	// Reset notes:
	// Assertion reaches every flop at once, no clock needed.
	// Release is retimed so no flop leaves reset mid-setup.
	// Gated by ce, so ce low also stalls the release.
	// Keep ce high while reset is let go.
	// Two edges pass before the register slave listens.
	// Reset: asynchronous assert, release through two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else if (ce) begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Pin synchroniser: three flops and an agreement filter.
	// A pulse shorter than two clocks may be lost.
	// Filtered level lags the pin by about four edges.
	// Same filtered copy feeds reads and the parallel bus.
	// Pin inputs cross into the clock domain
	bpd_pin_sync u_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.ce        (ce),
		.pin_async (pin_in),
		.pin_level (pin_level)
	);

	// Bus timing, one access at a time:
	// Edge E0 sees the request with waitrequest high.
	// Waitrequest then drops for exactly one cycle.
	// Edge E1 sees it low; the write lands there.
	// Read data were captured at E0 and stand at E1.
	// Waitrequest is back high right after E1.
	// Master may raise its next request after E1.
	// Fixed latency keeps the slave free of counters.
	// Trade-off: every access costs two edges.
	// Bus decode
	wire       bus_req   = avs_read | avs_write;
	// Request seen while still stalled: answer on next cycle
	wire       bus_take  = bus_req & avs_waitrequest;
	// Write lands only at the edge where waitrequest is sampled low
	wire       wr_fire   = avs_write & ~avs_waitrequest
			       & avs_byteenable[0];
	wire [7:0] wr_byte   = avs_writedata[7:0];
	wire       aligned   = (avs_address[1:0] == 2'h0);

	// Register map, all in byte 0; only pin levels, latch and direction use all eight bits:
	// 00 pin levels on read, latch on write.
	// 04 output latch, reads back the latch.
	// 08 direction, one floats a pin.
	// 0C companion, bit 7 shared pull-up enable.
	// 10 parallel control, bit 0 takes the port.
	// 14 PWM control: active, mode, float on shutdown.
	// Misaligned or unmapped: read zero, write dropped.
	// Upper bytes ignored on write, zero on read.
	// Register selects
	wire sel_pin  = aligned & (avs_address == BPD_OFS_PIN_LEVEL);
	wire sel_lat  = aligned & (avs_address == BPD_OFS_LATCH);
	wire sel_dir  = aligned & (avs_address == BPD_OFS_DIR);
	wire sel_comp = aligned & (avs_address == BPD_OFS_COMPANION);
	wire sel_par  = aligned & (avs_address == BPD_OFS_PARALLEL);
	wire sel_pwm  = aligned & (avs_address == BPD_OFS_PWM);

	// Write strobes per register
	wire wr_pin  = wr_fire & sel_pin;
	wire wr_lat  = wr_fire & sel_lat;
	wire wr_dir  = wr_fire & sel_dir;
	wire wr_comp = wr_fire & sel_comp;
	wire wr_par  = wr_fire & sel_par;
	wire wr_pwm  = wr_fire & sel_pwm;

	// Read path is a plain priority select.
	// Selects are one-hot, so order does not matter.
	// Pin read sees filtered levels, some edges late.
	// Software wanting its own value reads the latch.
	// Read views; unused bits read as zero
	wire [7:0] rd_comp = {pullup_master_enable, 7'h00};
	wire [7:0] rd_par  = {7'h00, par_enable};
	wire [7:0] rd_pwm  = {4'h0, pwm_tri_on_shutdown, pwm_mode,
			      pwm_active};

	wire [7:0] rd_byte =
		sel_pin  ? pin_level :
		sel_lat  ? output_latch_reg :
		sel_dir  ? direction_reg :
		sel_comp ? rd_comp :
		sel_par  ? rd_par :
		sel_pwm  ? rd_pwm : 8'h00;

	// Waitrequest idles high, so a stalled master waits.
	// A request seen with waitrequest high is always answered.
	// Low lasts one cycle; holding the request longer
	// starts a second access, which the master must avoid.
	// One wait cycle per access, then a single low cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else if (ce)
			avs_waitrequest <= ~bus_take;
	end

	// Read data captured as waitrequest drops, held until next
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			avs_readdata <= BPD_RST_RDATA;
		else if (ce && bus_take)
			avs_readdata <= {24'h000000, rd_byte};
	end

	// Both data registers land in the same latch, so
	// read-modify-write on 04 never picks up pin levels; on 00 it does.
	// Byte enable 0 low drops the write entirely.
	// Latch accepts writes through either data register
	// Pin register write lands in latch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			output_latch_reg <= BPD_RST_LATCH;
		else if (ce && (wr_pin || wr_lat))
			output_latch_reg <= wr_byte;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			direction_reg <= BPD_RST_DIR;
		else if (ce && wr_dir)
			direction_reg <= wr_byte;
	end

	// Shared enable alone does nothing; latch bits pick pins.
	// Every pull-up stays off until software sets it.
	// Shared enable in bit 7
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pullup_master_enable <= BPD_RST_PULLUP;
		else if (ce && wr_comp)
			pullup_master_enable <= wr_byte[BPD_COMP_PULLUP_BIT];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			par_enable <= BPD_RST_PAR_EN;
		else if (ce && wr_par)
			par_enable <= wr_byte[BPD_PAR_EN_BIT];
	end

	// PWM routing control
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_active          <= BPD_RST_PWM[BPD_PWM_ACTIVE_BIT];
			pwm_mode            <= BPD_RST_PWM[BPD_PWM_MODE_MSB:
							   BPD_PWM_MODE_LSB];
			pwm_tri_on_shutdown <= BPD_RST_PWM[BPD_PWM_TRI_BIT];
		end else if (ce && wr_pwm) begin
			pwm_active          <= wr_byte[BPD_PWM_ACTIVE_BIT];
			pwm_mode            <= wr_byte[BPD_PWM_MODE_MSB:
						       BPD_PWM_MODE_LSB];
			pwm_tri_on_shutdown <= wr_byte[BPD_PWM_TRI_BIT];
		end
	end

	// PWM ownership of the upper pins:
	// Single mode keeps channel A elsewhere; no pin here.
	// Dual mode claims pin 5 for channel B.
	// Both quad modes claim pins 5, 6 and 7.
	// Inactive PWM claims nothing, whatever the mode.
	// A claimed pin still needs its direction bit at zero.
	// With direction one the pin falls back to lower priority.
	// Serial unit is told whenever pin 5 is claimed.
	// Channel ownership by output mode
	wire pwm_quad = (pwm_mode == BPD_PWM_QUAD_FWD)
		      | (pwm_mode == BPD_PWM_QUAD_REV);
	wire pwm_dual = (pwm_mode == BPD_PWM_DUAL);
	wire own_b    = pwm_active & (pwm_quad | pwm_dual);
	wire own_cd   = pwm_active & pwm_quad;

	// Channels B, C, D on pins 5-7
	wire [BPD_WIDTH-1:0] pwm_assign =
		{own_cd, own_cd, own_b, 5'h00};
	wire [BPD_WIDTH-1:0] pwm_data =
		{pwm_out_d, pwm_out_c, pwm_out_b, 5'h00};

	// Float only when software allows it
	wire pwm_tristate = pwm_tri_on_shutdown & pwm_shutdown;

	// Serial unit off for dual or quad
	wire next_serial_off = own_b;

	// Priority per pin, highest first:
	// PWM channel, when claimed and direction is zero.
	// Parallel bus, when enabled and driving; ignores direction.
	// Output latch, when direction is zero.
	// Otherwise the pin floats.
	// Pull-up only on a floating pin no peripheral owns.
	// Priority mux per pin
	bpd_pin_mux u_mux (
		.dir           (direction_reg),
		.latch         (output_latch_reg),
		.pullup_master (pullup_master_enable),
		.par_en        (par_enable),
		.par_drive     (par_drive),
		.par_data      (par_out_data),
		.pwm_assign    (pwm_assign),
		.pwm_data      (pwm_data),
		.pwm_tristate  (pwm_tristate),
		.next_out      (next_out),
		.next_oe       (next_oe),
		.next_pullup   (next_pullup)
	);

	// Registering the pins keeps glitches off the board.
	// Every control change shows one edge after it lands.
	// Output enable high means the block drives the pin.
	// Pin value is a don't-care while enable is low.
	// Pin drive registered; costs one cycle of latency per change
	// Floated pins drop enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_out <= BPD_RST_LATCH;
			pin_oe  <= ~BPD_RST_DIR;
		end else if (ce) begin
			pin_out <= next_out;
			pin_oe  <= next_oe;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			pin_pullup_en <= {BPD_WIDTH{BPD_RST_PULLUP}};
		else if (ce)
			pin_pullup_en <= next_pullup;
	end

	// Parallel bus sees pins whatever the direction bits,
	// so it can read back what it drives itself.
	// One edge later than the pin register view.
	// Pin levels to parallel bus
	// Filtered copy, so the bus sees no metastable bits
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			par_in_data <= BPD_RST_PIN;
		else if (ce)
			par_in_data <= pin_level;
	end

	// Tell parallel logic it owns port
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			par_port_enable <= BPD_RST_PAR_EN;
		else if (ce)
			par_port_enable <= par_enable;
	end

	// Serial unit disable follows pin 5 ownership.
	// Registered, so it trails a PWM write by one edge.
	// Serial unit must not drive while this is high.
	// Registered disable to serial unit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			serial_unit_port_disable <= 1'b0;
		else if (ce)
			serial_unit_port_disable <= next_serial_off;
	end

endmodule

`default_nettype wire

/* verif/bpd_board_model.sv */
// Board-side model of the eight port pins.
// Assumes the bench sets an external driver; undriven pins wander.
`timescale 1ns/1ps
`default_nettype none
module bpd_board_model
	import bpd_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic [BPD_WIDTH-1:0] pin_out,
	input  wire logic [BPD_WIDTH-1:0] pin_oe,
	input  wire logic [BPD_WIDTH-1:0] pin_pullup_en,
	input  wire logic [BPD_WIDTH-1:0] ext_en,
	input  wire logic [BPD_WIDTH-1:0] ext_val,
	output logic      [BPD_WIDTH-1:0] pin_lvl
);
	logic [BPD_WIDTH-1:0] last = 8'h00;
	// Floating pins without pull-up toggle so a stale value never reads as a match
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup_en | ~last));
	always_ff @(posedge clk) begin
		last <= pin_lvl;
	end
endmodule
`default_nettype wire

/* verif/bpd_port_properties.sv */
// Port-level properties of the shared-pin port.
// Assumes ce high and the register bus on clk.
`timescale 1ns/1ps
`default_nettype none
module bpd_port_chk
	import bpd_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  pin_in,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe,
	input wire logic [7:0]  pin_pullup_en,
	input wire logic        par_drive,
	input wire logic [7:0]  par_out_data,
	input wire logic [7:0]  par_in_data,
	input wire logic        par_port_enable,
	input wire logic        pwm_out_b,
	input wire logic        serial_unit_port_disable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic sud = serial_unit_port_disable;
	wire logic ppe = par_port_enable;
	bus_answer_a: assert property ((avs_read || avs_write)
		&& avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	bus_idle_a: assert property (!avs_read && !avs_write
		|=> avs_waitrequest) else $error("waitrequest low when idle");
	rd_upper_a: assert property (!avs_waitrequest
		|-> avs_readdata[31:8] == 24'h000000) else $error("upper data set");
	pullup_out_a: assert property ((pin_pullup_en & pin_oe) == 8'h00)
		else $error("pull-up on a driven pin");
	pullup_par_a: assert property (ppe |-> pin_pullup_en == 8'h00)
		else $error("pull-up in parallel mode");
	pullup_pwm_a: assert property (sud |-> !pin_pullup_en[5])
		else $error("pull-up on pwm pin");
	par_over_a: assert property ((ppe && par_drive && !sud)
		##1 (ppe && !sud)
		|-> pin_out == $past(par_out_data) && pin_oe == 8'hFF)
		else $error("parallel drive lost");
	pwm_over_a: assert property ((sud && !ppe)
		##1 (sud && !ppe && pin_oe[5])
		|-> pin_out[5] == $past(pwm_out_b)) else $error("pwm b not on pin");
	par_in_a: assert property ($stable(pin_in) [*8]
		|-> par_in_data == pin_in) else $error("parallel input stale");
	rst_quiet_a: assert property ($rose(resetn)
		|-> pin_pullup_en == 8'h00 && pin_oe == 8'h00) else $error("reset pins");
	cover property (ppe && par_drive);
	cover property (sud && pin_oe[5]);
	cover property (pin_pullup_en != 8'h00);
endmodule
bind bpd_port bpd_port_chk bpd_port_chk_i (.clk(clk), .resetn(resetn),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
	.pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en), .par_drive(par_drive),
	.par_out_data(par_out_data), .par_in_data(par_in_data),
	.par_port_enable(par_port_enable), .pwm_out_b(pwm_out_b),
	.serial_unit_port_disable(serial_unit_port_disable));
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the shared-pin port.
// Assumes one 40 MHz clock and the board model on the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bpd_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] adr = 5'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic pd = 1'b0;
	logic [7:0] pod = 8'h00;
	logic [2:0] pwm = 3'h0;
	logic sd = 1'b0;
	logic [7:0] ee = 8'h00;
	logic [7:0] ev = 8'h00;
	int bad_count = 0;
	int tests_run = 0;
	wire logic [31:0] rdo;
	wire logic wrq, ppe, sud;
	wire logic [7:0] pin, po, poe, pup, pin_d;
	logic [2:0] own[4] = '{3'h0, 3'h7, 3'h1, 3'h7};
	bpd_port bpd_port_i (.clk(clk), .resetn(resetn), .ce(1'b1),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(4'hF), .avs_readdata(rdo), .avs_waitrequest(wrq),
		.pin_in(pin), .pin_out(po), .pin_oe(poe), .pin_pullup_en(pup),
		.par_drive(pd), .par_out_data(pod), .par_in_data(pin_d),
		.par_port_enable(ppe), .pwm_out_b(pwm[0]), .pwm_out_c(pwm[1]),
		.pwm_out_d(pwm[2]), .pwm_shutdown(sd), .serial_unit_port_disable(sud));
	bpd_board_model bpd_board_model_i (.clk(clk), .pin_out(po), .pin_oe(poe),
		.pin_pullup_en(pup), .ext_en(ee), .ext_val(ev), .pin_lvl(pin));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic conclude();
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= {24'h000000, d};
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
			n++;
		end while (wrq !== 1'b0 && n < 50);
		rdata = rdo;
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 50) begin
			bad_count++;
			conclude();
		end
		@(posedge clk);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	initial begin
		idle(3);
		resetn <= 1'b1;
		idle(3);
		check(poe, 8'h00);
		check(pup, 8'h00);
		bus(0, BPD_OFS_DIR, 0); check(rdata, 32'h0000_00FF);
		bus(0, BPD_OFS_COMPANION, 0); check(rdata, 32'h0);
		bus(0, BPD_OFS_PWM, 0); check(rdata, 32'h0);
		bus(1, 5'h18, 8'hFF); bus(0, 5'h18, 0); check(rdata, 32'h0);
		$display("test reset done");
		bus(1, BPD_OFS_LATCH, 8'hA5); bus(1, BPD_OFS_DIR, 8'h00); idle(2);
		check(poe, 8'hFF);
		check(po, 8'hA5);
		idle(8); bus(0, BPD_OFS_PIN_LEVEL, 0); check(rdata, 32'hA5);
		ee <= 8'hFF; ev <= 8'h3C; bus(1, BPD_OFS_DIR, 8'hF0); idle(8);
		check(poe, 8'h0F);
		bus(0, BPD_OFS_PIN_LEVEL, 0); check(rdata, 32'h35);
		bus(0, BPD_OFS_LATCH, 0); check(rdata, 32'hA5);
		bus(1, BPD_OFS_PIN_LEVEL, 8'hF0); bus(0, BPD_OFS_LATCH, 0);
		check(rdata, 32'hF0);
		$display("test direction done");
		ee <= 8'h00; bus(1, BPD_OFS_COMPANION, 8'h80); idle(2);
		check(pup, 8'hF0);
		bus(0, BPD_OFS_COMPANION, 0); check(rdata, 32'h80);
		bus(1, BPD_OFS_DIR, 8'h00); idle(2); check(pup, 8'h00);
		bus(1, BPD_OFS_DIR, 8'hFF); bus(1, BPD_OFS_COMPANION, 8'h00); idle(2);
		check(pup, 8'h00);
		bus(1, BPD_OFS_COMPANION, 8'h80); bus(1, BPD_OFS_PARALLEL, 8'h01);
		pd <= 1'b1; pod <= 8'h5A; idle(3);
		check({ppe, poe, po}, {1'b1, 16'hFF5A});
		check(pup, 8'h00);
		pd <= 1'b0; ee <= 8'hFF; ev <= 8'hC3; idle(10);
		check({poe, pin_d}, 16'h00C3);
		bus(1, BPD_OFS_PARALLEL, 8'h00); $display("test parallel done");
		bus(1, BPD_OFS_DIR, 8'h00); pwm <= 3'h5;
		// Unclaimed upper pins still show latch F0, all ones
		for (int m = 0; m < 4; m++) begin
			sd <= 1'b0; bus(1, BPD_OFS_PWM, 8'h09 | 8'(m << 1)); idle(3);
			check(sud, m != 0);
			check(po[7:5], 3'((own[m] & 3'h5) | (~own[m] & 3'h7)));
			sd <= 1'b1; idle(3); check(poe[7:5], 3'(~own[m]));
		end
		$display("test pwm done");
		conclude();
	end
endmodule
`default_nettype wire
